// file: design/tec_defines.vh
// Purpose: shared constants for the 16-bit timer/event counter block
// Assumes: register indices are word indices, byte address = index * 4
// Notes: definitions only, no logic
`ifndef TEC_DEFINES_VH
`define TEC_DEFINES_VH

// =====================================================================
// register indices (byte address is four times the index)
// =====================================================================
`define TEC_IDX_COUNT 16'hffb0
`define TEC_IDX_CAPCMP0 16'hffb2
`define TEC_IDX_CAPCMP1 16'hffb4
`define TEC_IDX_MODE 16'hffba
`define TEC_IDX_PRESCALE 16'hffbb
`define TEC_IDX_CAPCTL 16'hffbc
`define TEC_IDX_OUTCTL 16'hffbd

// =====================================================================
// timer_mode_control fields
// =====================================================================
`define TEC_MODE_OPEN_HI 3
`define TEC_MODE_OPEN_LO 2
`define TEC_MODE_REV_BIT 1
`define TEC_MODE_OVF_BIT 0
`define TEC_OPEN_STOP 2'h0
`define TEC_OPEN_FREE 2'h1
`define TEC_OPEN_CLR_PIN 2'h2
`define TEC_OPEN_CLR_MATCH 2'h3

// =====================================================================
// capcmp_control fields
// =====================================================================
`define TEC_CC_FIRST_MODE 0
`define TEC_CC_FIRST_TRIG 1
`define TEC_CC_SECOND_MODE 2

// =====================================================================
// prescaler_edge_mode fields and edge encodings
// =====================================================================
`define TEC_PS_BEDGE_HI 7
`define TEC_PS_BEDGE_LO 6
`define TEC_PS_AEDGE_HI 5
`define TEC_PS_AEDGE_LO 4
`define TEC_PS_CLK_HI 1
`define TEC_PS_CLK_LO 0
`define TEC_EDGE_FALL 2'h0
`define TEC_EDGE_RISE 2'h1
`define TEC_EDGE_BOTH 2'h3
`define TEC_CLK_DIV1 2'h0
`define TEC_CLK_DIV4 2'h1
`define TEC_CLK_DIV256 2'h2
`define TEC_CLK_PIN 2'h3

// =====================================================================
// output control fields and reset values
// =====================================================================
`define TEC_OC_ONESHOT_TRIG 6
`define TEC_RST_BYTE 8'h00
`define TEC_RST_WORD 16'h0000
`define TEC_CNT_MAX 16'hffff

`endif

// file: design/tec_edge_sync.v
// Purpose: synchronise one timer input pin and detect its edges
// Assumes: pin is asynchronous to clk
// Notes: rise and fall are one-cycle pulses in the clk domain
`timescale 1ns/1ns

module tec_edge_sync (
	input wire clk,
	input wire rst,
	input wire pinIn,
	output wire rise,
	output wire fall
);

	reg meta_r;
	reg sync_r;
	reg prev_r;

	// =================================================================
	// two-stage synchroniser plus history flop
	// =================================================================
	// first stage feeds only the second stage
	always @(posedge clk) begin
		if (rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= pinIn;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// single-cycle edge strobes
	assign rise = sync_r & ~prev_r;
	assign fall = ~sync_r & prev_r;

endmodule // tec_edge_sync

// file: design/tec_timer.v
// Purpose: 16-bit timer/event counter with two capture/compare registers
// Assumes: APB slave, 100 MHz clk, synchronous active-high reset
// Notes: zero-wait-state APB; match outputs are one-cycle pulses
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`include "tec_defines.vh"

module tec_timer #(
	parameter ADDR_W = 18
) (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire timerInputA,
	input wire timerInputB,
	output wire matchIrqFirst,
	output wire matchIrqSecond
);

	// =================================================================
	// functions
	// =================================================================
	// valid edge hit for a two-bit edge field
	function edgeHit;
		input [1:0] sel;
		input r;
		input f;
		begin
			case (sel)
				`TEC_EDGE_FALL: edgeHit = f;
				`TEC_EDGE_RISE: edgeHit = r;
				`TEC_EDGE_BOTH: edgeHit = r | f;
				default: edgeHit = 1'b0;
			endcase
		end
	endfunction

	// decode a byte address against a register index
	function isReg;
		input [ADDR_W-1:0] addr;
		input [15:0] idx;
		begin
			isReg = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
		end
	endfunction

	// =================================================================
	// declarations
	// =================================================================
	reg [7:0] modeCtl_r;
	reg [7:0] prescale_r;
	reg [7:0] capCtl_r;
	reg [7:0] outCtl_r;
	reg [15:0] count_r;
	reg [15:0] count_nxt;
	reg [15:0] capFirst_r;
	reg [15:0] capSecond_r;
	reg [7:0] pscCnt_r;
	reg freshStart_r;
	reg irqFirst_r;
	reg irqSecond_r;
	reg [31:0] rdata_r;
	reg [31:0] rdata_nxt;
	reg tick;
	wire riseA;
	wire fallA;
	wire riseB;
	wire fallB;
	wire [1:0] opEnable;
	wire running;
	wire validA;
	wire oppositeA;
	wire validB;
	wire firstCapMode;
	wire secondCapMode;
	wire firstTrigSel;
	wire setupPhase;
	wire wrAccess;
	wire addrHit;
	wire wrMode;
	wire wrOneShot;
	wire matchFirst;
	wire matchSecond;
	wire clearStart;
	wire wrap;
	wire capFirstEv;
	wire capSecondEv;

	// =================================================================
	// input pin synchronisers
	// =================================================================
	// both pins pass two flops before edge logic
	tec_edge_sync uSyncA (
		.clk(clk),
		.rst(rst),
		.pinIn(timerInputA),
		.rise(riseA),
		.fall(fallA)
	);

	tec_edge_sync uSyncB (
		.clk(clk),
		.rst(rst),
		.pinIn(timerInputB),
		.rise(riseB),
		.fall(fallB)
	);

	// =================================================================
	// control decode
	// =================================================================
	// operation-enable field and mode bits
	assign opEnable = modeCtl_r[`TEC_MODE_OPEN_HI:`TEC_MODE_OPEN_LO];
	assign running = (opEnable != `TEC_OPEN_STOP);
	assign firstCapMode = capCtl_r[`TEC_CC_FIRST_MODE];
	assign firstTrigSel = capCtl_r[`TEC_CC_FIRST_TRIG];
	assign secondCapMode = capCtl_r[`TEC_CC_SECOND_MODE];

	// valid edges of both pins, and opposite phase of pin A
	assign validA = edgeHit(prescale_r[`TEC_PS_AEDGE_HI:`TEC_PS_AEDGE_LO], riseA, fallA);
	assign validB = edgeHit(prescale_r[`TEC_PS_BEDGE_HI:`TEC_PS_BEDGE_LO], riseB, fallB);
	// both-edge setting leaves no opposite phase to detect
	assign oppositeA = (prescale_r[`TEC_PS_AEDGE_HI:`TEC_PS_AEDGE_LO] == `TEC_EDGE_BOTH) ?
		1'b0 : edgeHit(prescale_r[`TEC_PS_AEDGE_HI:`TEC_PS_AEDGE_LO], fallA, riseA);

	// =================================================================
	// count clock selection
	// =================================================================
	// prescale counter runs only while the timer is enabled
	always @(posedge clk) begin
		if (rst || !running) begin
			pscCnt_r <= `TEC_RST_BYTE;
		end else begin
			pscCnt_r <= pscCnt_r + 8'h01;
		end
	end

	// one tick per selected count clock edge
	always @* begin
		case (prescale_r[`TEC_PS_CLK_HI:`TEC_PS_CLK_LO])
			`TEC_CLK_DIV1: tick = running;
			`TEC_CLK_DIV4: tick = running && (pscCnt_r[1:0] == 2'h3);
			`TEC_CLK_DIV256: tick = running && (pscCnt_r == 8'hff);
			`TEC_CLK_PIN: tick = running && validA;
			default: tick = 1'b0;
		endcase
	end

	// =================================================================
	// compare, clear and overflow events
	// =================================================================
	// match judged at the tick that leaves the compared value; a zero
	// compare value therefore matches on the step 0000 to 0001, and the
	// first step after a start is excluded
	assign matchFirst = tick && !firstCapMode && !freshStart_r && (count_r == capFirst_r);
	assign matchSecond = tick && !secondCapMode && !freshStart_r && (count_r == capSecond_r);

	// clear-and-start condition of the active mode
	assign clearStart = running && (
		((opEnable == `TEC_OPEN_CLR_PIN) && validA) ||
		((opEnable == `TEC_OPEN_CLR_MATCH) && matchFirst) ||
		wrOneShot);
	assign wrap = tick && (count_r == `TEC_CNT_MAX) && !clearStart;

	// capture triggers, ignored in compare mode or while stopped
	assign capFirstEv = running && firstCapMode &&
		(firstTrigSel ? oppositeA : validB);
	assign capSecondEv = running && secondCapMode && validA;

	// suppress matches on the first count after a start
	always @(posedge clk) begin
		if (rst || !running) begin
			freshStart_r <= 1'b1;
		end else if (tick) begin
			freshStart_r <= 1'b0;
		end
	end

	// =================================================================
	// counter
	// =================================================================
	// next counter value, clear has priority over counting
	always @* begin
		count_nxt = count_r;
		if (!running) begin
			count_nxt = `TEC_RST_WORD;
		end else if (clearStart) begin
			count_nxt = `TEC_RST_WORD;
		end else if (tick) begin
			count_nxt = count_r + 16'h0001;
		end
	end

	// counter register
	always @(posedge clk) begin
		if (rst) begin
			count_r <= `TEC_RST_WORD;
		end else begin
			count_r <= count_nxt;
		end
	end

	// =================================================================
	// apb decode
	// =================================================================
	// zero wait states, error on unmapped word
	assign setupPhase = psel && !penable;
	assign wrAccess = psel && penable && pwrite && addrHit;
	assign addrHit = isReg(paddr, `TEC_IDX_COUNT) || isReg(paddr, `TEC_IDX_CAPCMP0) ||
		isReg(paddr, `TEC_IDX_CAPCMP1) || isReg(paddr, `TEC_IDX_MODE) ||
		isReg(paddr, `TEC_IDX_PRESCALE) || isReg(paddr, `TEC_IDX_CAPCTL) ||
		isReg(paddr, `TEC_IDX_OUTCTL);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addrHit;
	assign prdata = rdata_r;
	assign wrMode = wrAccess && isReg(paddr, `TEC_IDX_MODE);
	assign wrOneShot = wrAccess && isReg(paddr, `TEC_IDX_OUTCTL) &&
		pwdata[`TEC_OC_ONESHOT_TRIG];

	// =================================================================
	// mode control register
	// =================================================================
	// overflow set by wrap wins over any clearing write
	always @(posedge clk) begin
		if (rst) begin
			modeCtl_r <= `TEC_RST_BYTE;
		end else begin
			if (wrMode) begin
				modeCtl_r[`TEC_MODE_OPEN_HI:`TEC_MODE_REV_BIT] <= pwdata[3:1];
				if (pwdata[3:2] == `TEC_OPEN_STOP) begin
					modeCtl_r[`TEC_MODE_OVF_BIT] <= wrap;
				end else begin
					modeCtl_r[`TEC_MODE_OVF_BIT] <= pwdata[0] | wrap;
				end
			end else if (wrap) begin
				modeCtl_r[`TEC_MODE_OVF_BIT] <= 1'b1;
			end
		end
	end

	// =================================================================
	// prescaler, capture control and output control registers
	// =================================================================
	// plain storage; the one-shot bit never stores
	always @(posedge clk) begin
		if (rst) begin
			prescale_r <= `TEC_RST_BYTE;
			capCtl_r <= `TEC_RST_BYTE;
			outCtl_r <= `TEC_RST_BYTE;
		end else begin
			if (wrAccess && isReg(paddr, `TEC_IDX_PRESCALE)) begin
				prescale_r <= {pwdata[7:4], 2'h0, pwdata[1:0]};
			end
			if (wrAccess && isReg(paddr, `TEC_IDX_CAPCTL)) begin
				capCtl_r <= {5'h00, pwdata[2:0]};
			end
			if (wrAccess && isReg(paddr, `TEC_IDX_OUTCTL)) begin
				outCtl_r <= {1'b0, 1'b0, pwdata[5:0]};
			end
		end
	end

	// =================================================================
	// capture/compare registers
	// =================================================================
	// capture wins over a software write in the same cycle; a capture
	// in the cycle of a stopping write is still taken, since running only drops at the next edge
	always @(posedge clk) begin
		if (rst) begin
			capFirst_r <= `TEC_RST_WORD;
			capSecond_r <= `TEC_RST_WORD;
		end else begin
			if (capFirstEv) begin
				capFirst_r <= count_r;
			end else if (wrAccess && isReg(paddr, `TEC_IDX_CAPCMP0)) begin
				capFirst_r <= pwdata[15:0];
			end
			if (capSecondEv) begin
				capSecond_r <= count_r;
			end else if (wrAccess && isReg(paddr, `TEC_IDX_CAPCMP1)) begin
				capSecond_r <= pwdata[15:0];
			end
		end
	end

	// =================================================================
	// interrupt request pulses
	// =================================================================
	// first irq: compare match, or input B edge in capture mode
	always @(posedge clk) begin
		if (rst) begin
			irqFirst_r <= 1'b0;
			irqSecond_r <= 1'b0;
		end else begin
			irqFirst_r <= matchFirst || (running && firstCapMode && validB);
			irqSecond_r <= matchSecond;
		end
	end

	assign matchIrqFirst = irqFirst_r;
	assign matchIrqSecond = irqSecond_r;

	// =================================================================
	// read data
	// =================================================================
	// read data selected in setup phase, presented in access phase
	always @* begin
		rdata_nxt = 32'h00000000;
		if (isReg(paddr, `TEC_IDX_COUNT)) begin
			rdata_nxt = {16'h0000, running ? count_r : `TEC_RST_WORD};
		end else if (isReg(paddr, `TEC_IDX_CAPCMP0)) begin
			rdata_nxt = {16'h0000, capFirst_r};
		end else if (isReg(paddr, `TEC_IDX_CAPCMP1)) begin
			rdata_nxt = {16'h0000, capSecond_r};
		end else if (isReg(paddr, `TEC_IDX_MODE)) begin
			rdata_nxt = {24'h000000, modeCtl_r};
		end else if (isReg(paddr, `TEC_IDX_PRESCALE)) begin
			rdata_nxt = {24'h000000, prescale_r};
		end else if (isReg(paddr, `TEC_IDX_CAPCTL)) begin
			rdata_nxt = {24'h000000, capCtl_r};
		end else if (isReg(paddr, `TEC_IDX_OUTCTL)) begin
			rdata_nxt = {24'h000000, outCtl_r};
		end
	end

	// read data register, loaded only on a setup cycle
	always @(posedge clk) begin
		if (rst) begin
			rdata_r <= 32'h00000000;
		end else if (setupPhase && !pwrite) begin
			rdata_r <= rdata_nxt;
		end
	end

endmodule // tec_timer

// file: tb/tec_timer_checker.sv
// Purpose: port checks for the timer top
// Assumes: one clock, synchronous reset
// Notes: mirrors the operation-enable field from bus writes
`timescale 1ns/1ns
`include "tec_defines.vh"

module tec_timer_checker #(
	parameter ADDR_W = 18
) (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire timerInputA,
	input wire timerInputB,
	input wire matchIrqFirst,
	input wire matchIrqSecond
);
	// =====================================================================
	// helper logic
	// =====================================================================
	wire [15:0] rIdx = paddr[ADDR_W-1:2];
	wire acc = psel && penable && paddr[1:0] == 2'h0;
	wire rdAcc = acc && !pwrite;
	reg [1:0] opEn_r;

	// mirror of the operation-enable field
	always @(posedge clk) begin
		if (rst)
			opEn_r <= 2'h0;
		else if (acc && pwrite && rIdx == `TEC_IDX_MODE)
			opEn_r <= pwdata[3:2];
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// =====================================================================
	// assertions
	// =====================================================================
	property p_cnt_stop;
		rdAcc && rIdx == `TEC_IDX_COUNT && opEn_r == 2'h0 |-> prdata == 32'h0;
	endproperty
	a_cnt_stop: assert property (p_cnt_stop)
		else $error("count not zero while stopped");
	property p_cnt_width;
		rdAcc && rIdx == `TEC_IDX_COUNT |-> prdata[31:16] == 16'h0;
	endproperty
	a_cnt_width: assert property (p_cnt_width)
		else $error("count wider than 16 bits");
	property p_mode_rd;
		rdAcc && rIdx == `TEC_IDX_MODE |-> prdata[31:4] == 28'h0 && prdata[3:2] == opEn_r;
	endproperty
	a_mode_rd: assert property (p_mode_rd)
		else $error("mode register read wrong");
	property p_cc_width;
		rdAcc && (rIdx == `TEC_IDX_CAPCMP0 || rIdx == `TEC_IDX_CAPCMP1) |-> prdata[31:16] == 16'h0;
	endproperty
	a_cc_width: assert property (p_cc_width)
		else $error("capture register wider than 16 bits");
	property p_irq1_pulse;
		$rose(matchIrqFirst) |=> !matchIrqFirst;
	endproperty
	a_irq1_pulse: assert property (p_irq1_pulse)
		else $error("first request longer than one cycle");
	property p_irq2_pulse;
		$rose(matchIrqSecond) |=> !matchIrqSecond;
	endproperty
	a_irq2_pulse: assert property (p_irq2_pulse)
		else $error("second request longer than one cycle");
	property p_idle_quiet;
		(opEn_r == 2'h0) [*3] |-> !matchIrqFirst && !matchIrqSecond;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("request while stopped");
	property p_trig_reads0;
		rdAcc && rIdx == `TEC_IDX_OUTCTL |-> prdata[6] == 1'b0;
	endproperty
	a_trig_reads0: assert property (p_trig_reads0)
		else $error("one-shot trigger bit read as one");

	// main scenarios reached
	c_irq1: cover property (matchIrqFirst);
	c_irq2: cover property (matchIrqSecond);
	c_err: cover property (pslverr);
endmodule // tec_timer_checker

bind tec_timer tec_timer_checker #(.ADDR_W(ADDR_W)) i_chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .timerInputA(timerInputA),
	.timerInputB(timerInputB), .matchIrqFirst(matchIrqFirst), .matchIrqSecond(matchIrqSecond));

// file: tb/tec_pin_source.sv
// Purpose: external pulse source for the two timer input pins
// Assumes: push-pull drive, idle low
// Notes: each level held six clocks, well above the sync delay
`timescale 1ns/1ns

module tec_pin_source (
	input wire clk,
	output logic pinA,
	output logic pinB
);
	initial begin
		pinA = 1'b0;
		pinB = 1'b0;
	end

	// one high pulse on the chosen pin
	task automatic pulse(input bit onB);
		@(posedge clk);
		if (onB)
			pinB <= 1'b1;
		else
			pinA <= 1'b1;
		repeat (6) @(posedge clk);
		if (onB)
			pinB <= 1'b0;
		else
			pinA <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
endmodule // tec_pin_source

// file: tb/tb_timer_event_counter_capture.sv
// Purpose: self-checking bench for the timer block
// Assumes: zero-wait APB slave, 100 MHz clock
// Notes: software keeps the timer stopped while reconfiguring
`timescale 1ns/1ns
`include "tec_defines.vh"

`define TEC_CHK(what, exp, got) begin \
	checked++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("wrong value %s expected %h seen %h", what, exp, got); \
	end \
end

module tb_timer_event_counter_capture;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, pinA, pinB, irq1, irq2, e;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, d, s, f, c;
	int n_errors, checked, cyc, n1, n2, last1, last2, gap1, gap2, b;
	logic [15:0] regIdx [6] = '{`TEC_IDX_COUNT, `TEC_IDX_CAPCMP0, `TEC_IDX_CAPCMP1,
		`TEC_IDX_MODE, `TEC_IDX_PRESCALE, `TEC_IDX_CAPCTL};

	tec_timer i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timerInputA(pinA), .timerInputB(pinB), .matchIrqFirst(irq1), .matchIrqSecond(irq2));
	tec_pin_source i_src (.clk(clk), .pinA(pinA), .pinB(pinB));

	// =====================================================================
	// clock, request monitor and timeout
	// =====================================================================
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (irq1 === 1'b1) begin
			gap1 = cyc - last1;
			last1 = cyc;
			n1++;
		end
		if (irq2 === 1'b1) begin
			gap2 = cyc - last2;
			last2 = cyc;
			n2++;
		end
		if (cyc == 80000) begin
			n_errors++;
			wrap_up();
		end
	end

	// =====================================================================
	// report and bus tasks
	// =====================================================================
	task wrap_up;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
		output logic [31:0] rv, output logic er);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
		logic [31:0] x;
		logic y;
		apb(1'b1, idx, wd, x, y);
	endtask
	task automatic rd(input logic [15:0] idx, output logic [31:0] v);
		logic y;
		apb(1'b0, idx, 32'h0, v, y);
	endtask

	// =====================================================================
	// main sequence
	// =====================================================================
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = '0;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		foreach (regIdx[i]) begin
			rd(regIdx[i], d);
			`TEC_CHK("reset value", 32'h0, d)
		end
		apb(1'b0, 16'h0010, 32'h0, d, e);
		`TEC_CHK("unmapped error", 1'b1, e)
		// free run, one-shot clear, stop and restart
		wr(`TEC_IDX_MODE, 32'h4);
		rd(`TEC_IDX_COUNT, c);
		rd(`TEC_IDX_COUNT, d);
		`TEC_CHK("count step", c + 32'h3, d)
		wr(`TEC_IDX_OUTCTL, 32'h40);
		rd(`TEC_IDX_COUNT, d);
		`TEC_CHK("one-shot clear", 1'b1, d < 32'h4)
		wr(`TEC_IDX_MODE, 32'h0);
		rd(`TEC_IDX_COUNT, d);
		`TEC_CHK("stopped count", 32'h0, d)
		wr(`TEC_IDX_MODE, 32'h4);
		rd(`TEC_IDX_COUNT, d);
		`TEC_CHK("restart count", 1'b1, d < 32'h4)
		// clear on first match, period N+1
		wr(`TEC_IDX_MODE, 32'h0);
		wr(`TEC_IDX_CAPCMP0, 32'h5);
		wr(`TEC_IDX_CAPCMP1, 32'h3);
		wr(`TEC_IDX_MODE, 32'hc);
		repeat (40) @(posedge clk);
		`TEC_CHK("first period", 6, gap1)
		`TEC_CHK("second period", 6, gap2)
		// second captures on input A, first on input B
		wr(`TEC_IDX_MODE, 32'h0);
		wr(`TEC_IDX_PRESCALE, 32'h50);
		wr(`TEC_IDX_CAPCTL, 32'h5);
		wr(`TEC_IDX_MODE, 32'h4);
		b = n1;
		i_src.pulse(1'b0);
		rd(`TEC_IDX_CAPCMP1, s);
		rd(`TEC_IDX_CAPCMP0, f);
		rd(`TEC_IDX_COUNT, c);
		`TEC_CHK("first kept", 32'h5, f)
		`TEC_CHK("second captured", 1'b1, s != 0 && s < c)
		i_src.pulse(1'b1);
		rd(`TEC_IDX_CAPCMP0, f);
		`TEC_CHK("first captured", 1'b1, f > s)
		`TEC_CHK("b edge request", b + 1, n1)
		// first captures on opposite phase of input A
		wr(`TEC_IDX_MODE, 32'h0);
		wr(`TEC_IDX_CAPCTL, 32'h7);
		wr(`TEC_IDX_MODE, 32'h4);
		b = n1;
		i_src.pulse(1'b0);
		rd(`TEC_IDX_CAPCMP1, s);
		rd(`TEC_IDX_CAPCMP0, f);
		`TEC_CHK("second capture", 1'b1, s != 0)
		`TEC_CHK("opposite capture", 1'b1, f > s)
		`TEC_CHK("no capture request", b, n1)
		i_src.pulse(1'b1);
		rd(`TEC_IDX_CAPCMP0, d);
		`TEC_CHK("external request", b + 1, n1)
		`TEC_CHK("no b capture", f, d)
		// compare mode ignores triggers and count reads
		wr(`TEC_IDX_MODE, 32'h0);
		wr(`TEC_IDX_CAPCTL, 32'h0);
		wr(`TEC_IDX_CAPCMP0, 32'h1234);
		wr(`TEC_IDX_CAPCMP1, 32'h2345);
		wr(`TEC_IDX_MODE, 32'h4);
		i_src.pulse(1'b0);
		i_src.pulse(1'b1);
		rd(`TEC_IDX_COUNT, c);
		rd(`TEC_IDX_CAPCMP1, d);
		`TEC_CHK("second compare", 32'h2345, d)
		rd(`TEC_IDX_CAPCMP0, d);
		`TEC_CHK("first compare", 32'h1234, d)
		// zero compare and overflow on wrap
		wr(`TEC_IDX_MODE, 32'h0);
		wr(`TEC_IDX_CAPCMP1, 32'h0);
		wr(`TEC_IDX_MODE, 32'h4);
		b = n2;
		repeat (20) @(posedge clk);
		`TEC_CHK("no match at start", b, n2)
		repeat (65540) @(posedge clk);
		`TEC_CHK("match after wrap", b + 1, n2)
		rd(`TEC_IDX_MODE, d);
		`TEC_CHK("overflow set", 32'h5, d)
		wr(`TEC_IDX_MODE, 32'h0);
		rd(`TEC_IDX_MODE, d);
		`TEC_CHK("overflow cleared", 32'h0, d)
		// clear and start on input A edge: cleared three clocks after the pin rises
		wr(`TEC_IDX_MODE, 32'h8);
		b = n2;
		i_src.pulse(1'b0);
		rd(`TEC_IDX_COUNT, d);
		`TEC_CHK("pin clear count", 32'ha, d)
		`TEC_CHK("zero match after clear", b + 1, n2)
		// divide-by-four count clock, one step per four clocks
		wr(`TEC_IDX_MODE, 32'h0);
		wr(`TEC_IDX_PRESCALE, 32'h51);
		wr(`TEC_IDX_MODE, 32'h4);
		repeat (40) @(posedge clk);
		rd(`TEC_IDX_COUNT, d);
		`TEC_CHK("divided count", 32'ha, d)
		// second reset while the timer runs
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`TEC_IDX_COUNT, d);
		`TEC_CHK("count after reset", 32'h0, d)
		rd(`TEC_IDX_CAPCMP0, d);
		`TEC_CHK("first after reset", 32'h0, d)
		rd(`TEC_IDX_MODE, d);
		`TEC_CHK("mode after reset", 32'h0, d)
		wrap_up();
	end
endmodule // tb_timer_event_counter_capture
